// [design/rate_spi_pkg.sv]
package rate_spi_pkg;
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [31:0] FIRST_RESPONSE = 32'h0000_0001;
  localparam logic [31:0] ERROR_RESPONSE = 32'h0000_E000;
  localparam logic [15:0] ERROR_FLAG_SPI = 16'h2000;
  localparam int TAPS = 64;
  localparam int TAP_IDX_W = 6;
  localparam logic [TAP_IDX_W-1:0] LAST_TAP = 6'h3F;
  localparam int RATE_W = 16;
  localparam int SUM1_W = 22;
  localparam int SUM2_W = 28;
  localparam logic [3:0] ST_DIV_LAST = 4'hF;
  localparam int ST_W = 16;
  localparam int ST_ACC_W = 22;
  localparam int ST_SHIFT = 6;
  localparam logic [31:0] RESP_STATUS_RATE = 32'h0400_0000;
  localparam logic [31:0] RESP_STATUS_ST = 32'h0800_0000;
  localparam real T_GAP_US = 0.1;
  localparam real SYS_CLK_MHZ = 125.0;
  localparam int GAP_CYCLES_RAW = int'(T_GAP_US * SYS_CLK_MHZ);
  localparam int GAP_CYCLES = (GAP_CYCLES_RAW < 1) ? 1 : GAP_CYCLES_RAW;
endpackage

// [design/rate_sensor_spi_frame_engine.sv]
`timescale 1ns/10ps
module rate_sensor_spi_frame_engine (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic i_sample_stb,
  input wire logic signed [15:0] i_rate_sample,
  input wire logic [15:0] i_selftest_amp,
  output logic o_spi_miso,
  output logic o_spi_miso_oe_n,
  output logic o_cmd_valid,
  output logic [31:0] o_cmd_word,
  output logic o_frame_error,
  output logic signed [15:0] o_rate_filt,
  output logic [15:0] o_selftest_filt
);
  // ---------------- sensor sample domain (system clock) ----------------
  logic signed [15:0] tap_q [rate_spi_pkg::TAPS];
  logic signed [21:0] sum1_tap_q [rate_spi_pkg::TAPS];
  logic [5:0] tap_idx_q;
  logic signed [21:0] sum1_q;
  logic signed [27:0] sum2_q;
  logic [3:0] st_div_q;
  logic [21:0] st_acc_q;
  logic signed [21:0] sum1_d;

  assign sum1_d = sum1_q + 22'(i_rate_sample) - 22'(tap_q[tap_idx_q]);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tap_idx_q <= '0;
      sum1_q <= '0;
      sum2_q <= '0;
    end else if (i_sample_stb) begin
      tap_idx_q <= tap_idx_q + 6'h01;
      sum1_q <= sum1_d;
      sum2_q <= sum2_q + 28'(sum1_d) - 28'(sum1_tap_q[tap_idx_q]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < rate_spi_pkg::TAPS; g++) begin : g_tap
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          tap_q[g] <= '0;
          sum1_tap_q[g] <= '0;
        end else if (i_sample_stb && tap_idx_q == 6'(g)) begin
          tap_q[g] <= i_rate_sample;
          sum1_tap_q[g] <= sum1_d;
        end
      end
    end
  endgenerate

  // y = (x + 63 y) / 64, kept as acc = 64 y
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_div_q <= '0;
      st_acc_q <= '0;
    end else if (i_sample_stb) begin
      st_div_q <= st_div_q + 4'h1;
      if (st_div_q == rate_spi_pkg::ST_DIV_LAST) begin
        st_acc_q <= st_acc_q - (st_acc_q >> rate_spi_pkg::ST_SHIFT) + 22'(i_selftest_amp);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rate_filt <= '0;
      o_selftest_filt <= '0;
    end else begin
      o_rate_filt <= sum2_q[27:12];
      o_selftest_filt <= st_acc_q[21:6];
    end
  end

  // ---------------- cs synchroniser into system domain ----------------
  logic cs_meta_q, cs_sync_q, cs_prev_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      cs_meta_q <= i_spi_cs_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
    end
  end

  // snapshot at cs fall, held through idle gaps
  logic [31:0] snap_rate_q, snap_st_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      snap_rate_q <= '0;
      snap_st_q <= '0;
    end else if (cs_prev_q && !cs_sync_q) begin
      snap_rate_q <= rate_spi_pkg::RESP_STATUS_RATE | {6'h00, o_rate_filt, 10'h000};
      snap_st_q <= rate_spi_pkg::RESP_STATUS_ST | {6'h00, o_selftest_filt, 10'h000};
    end
  end

  // ---------------- link domain (sclk) ----------------
  logic [31:0] rx_sh_q;
  logic [5:0] bit_cnt_q;
  logic tx_bit;
  logic [31:0] tx_sh_q;
  // frame content is captured on cs rise in system domain
  logic [31:0] rx_hold_q;
  logic [5:0] cnt_hold_q;
  logic [31:0] resp_q;

  // cs high clears the frame flags; counter and shifter keep the last frame
  // so the system side can read them while the link clock stands still
  logic rx_live_q, tx_live_q;
  always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      rx_live_q <= 1'b0;
    end else begin
      rx_live_q <= 1'b1;
    end
  end

  always_ff @(posedge i_spi_sclk) begin
    if (rx_live_q) begin
      bit_cnt_q <= (bit_cnt_q == 6'h3F) ? bit_cnt_q : bit_cnt_q + 6'h01;
    end else begin
      bit_cnt_q <= 6'h01;
    end
    rx_sh_q <= {rx_sh_q[30:0], i_spi_mosi};
  end

  // miso changes on falling edge so the master samples late in the high phase, just before the next fall
  always_ff @(negedge i_spi_sclk or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      tx_live_q <= 1'b0;
    end else begin
      tx_live_q <= 1'b1;
    end
  end

  always_ff @(negedge i_spi_sclk) begin
    tx_sh_q <= tx_live_q ? {tx_sh_q[30:0], 1'b0} : {resp_q[30:0], 1'b0};
  end
  // resp_q only moves while cs is high, so it is quiet whenever sclk runs
  assign tx_bit = tx_live_q ? tx_sh_q[31] : resp_q[31];

  // link state is read only while cs is high and the link clock is still
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rx_hold_q <= '0;
      cnt_hold_q <= '0;
    end else if (!cs_prev_q && cs_sync_q) begin
      rx_hold_q <= rx_sh_q;
      cnt_hold_q <= bit_cnt_q;
    end
  end

  // ---------------- response build after cs rise ----------------
  // one cycle after the capture, so the held word and count have settled
  logic cs_rise_d1_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cs_rise_d1_q <= 1'b0;
    end else begin
      cs_rise_d1_q <= !cs_prev_q && cs_sync_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      resp_q <= rate_spi_pkg::FIRST_RESPONSE;
      o_cmd_valid <= 1'b0;
      o_cmd_word <= '0;
      o_frame_error <= 1'b0;
    end else begin
      o_cmd_valid <= 1'b0;
      // a bad bit count answers with the error word whatever the command
      if (cs_rise_d1_q) begin
        o_cmd_word <= rx_hold_q;
        if (cnt_hold_q != 6'(rate_spi_pkg::FRAME_BITS)) begin
          o_frame_error <= 1'b1;
          resp_q <= rate_spi_pkg::ERROR_RESPONSE | {16'h0000, rate_spi_pkg::ERROR_FLAG_SPI};
        end else begin
          o_frame_error <= 1'b0;
          o_cmd_valid <= 1'b1;
          resp_q <= rx_hold_q[29] ? snap_rate_q : snap_st_q;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_spi_miso <= 1'b0;
      o_spi_miso_oe_n <= 1'b1;
    end else begin
      // retimed so the pin comes from a flop; data settles within one system clock of the sclk fall
      o_spi_miso <= tx_bit;
      o_spi_miso_oe_n <= cs_sync_q;
    end
  end
endmodule // rate_sensor_spi_frame_engine

// [dv/spi_master_model.sv]
`timescale 1ns/10ps
module spi_master_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial {o_sclk, o_cs_n, o_mosi} = 3'b010;
  task automatic xfer(input logic [31:0] c, input int n, output logic [31:0] r);
    r = 32'h0;
    o_cs_n = 1'b0;
    #40; // lead lets the synchronised miso enable settle
    for (int b = 31; b > 31 - n; b--) begin
      o_mosi = c[b & 31];
      #7.5 o_sclk = 1'b1;
      #7.4 r = {r[30:0], i_miso};
      #0.1 o_sclk = 1'b0;
    end
    #8 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #120;
  endtask
endmodule // spi_master_model

// [dv/rate_spi_sva.sv]
`timescale 1ns/10ps
module rate_spi_sva (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe_n,
  input wire logic o_cmd_valid,
  input wire logic [31:0] o_cmd_word,
  input wire logic o_frame_error
);
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_oe_off; i_spi_cs_n [*5] |-> o_spi_miso_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe idle");
  property p_oe_on; !i_spi_cs_n [*5] |-> !o_spi_miso_oe_n; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe frame");
  property p_cv_one; o_cmd_valid |=> !o_cmd_valid; endproperty
  a_cv_one: assert property (p_cv_one) else $error("valid long");
  property p_cv_err; o_cmd_valid |-> !o_frame_error; endproperty
  a_cv_err: assert property (p_cv_err) else $error("valid err");
  property p_judge; $rose(i_spi_cs_n) |-> ##[1:8] (o_cmd_valid || o_frame_error); endproperty
  a_judge: assert property (p_judge) else $error("no verdict");
  property p_word; !i_spi_cs_n |-> $stable(o_cmd_word); endproperty
  a_word: assert property (p_word) else $error("word moved");
  property p_idle; i_spi_cs_n [*8] |=> $stable(o_spi_miso); endproperty
  a_idle: assert property (p_idle) else $error("miso moved");
  property p_ferr; !i_spi_cs_n |-> $stable(o_frame_error); endproperty
  a_ferr: assert property (p_ferr) else $error("err moved");
endmodule // rate_spi_sva
bind rate_sensor_spi_frame_engine rate_spi_sva sva_i (.i_sys_clk, .i_reset, .i_spi_cs_n,
  .o_spi_miso, .o_spi_miso_oe_n, .o_cmd_valid, .o_cmd_word, .o_frame_error);

// [dv/testbench.sv]
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_sample_stb = 1'b0;
  logic signed [15:0] i_rate_sample = 16'h0000;
  logic [15:0] i_selftest_amp = 16'h0000;
  logic sclk, cs_n, mosi, miso, oe_n, ferr, cv;
  logic [31:0] word, rsp, cmd;
  logic signed [15:0] filt;
  logic [15:0] stf;
  int error_cnt = 0, checked = 0, nv = 0, tick = 0, lvl = 0, s1 = 0, s2 = 0;
  int sta = 0, stc = 0;
  int q1[$], q2[$];
  wire miso_w = oe_n ? 1'b1 : miso;
  always #4 i_sys_clk = ~i_sys_clk;
  spi_master_model spi_master_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso_w));
  rate_sensor_spi_frame_engine rate_sensor_spi_frame_engine_i (.i_sys_clk, .i_reset,
    .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .i_sample_stb,
    .i_rate_sample, .i_selftest_amp, .o_spi_miso(miso), .o_spi_miso_oe_n(oe_n),
    .o_cmd_valid(cv), .o_cmd_word(word), .o_frame_error(ferr), .o_rate_filt(filt),
    .o_selftest_filt(stf));
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    if (cv === 1'b1) nv++;
    tick <= (tick + 1) % 8;
    i_sample_stb <= !i_reset && tick == 0;
    if (!i_reset && tick == 0) begin
      i_rate_sample <= lvl[15:0];
      i_selftest_amp <= lvl[15:0];
      q1.push_front(lvl);
      s1 += lvl;
      if (q1.size() > 64) s1 -= q1.pop_back();
      q2.push_front(s1);
      s2 += s1;
      if (q2.size() > 64) s2 -= q2.pop_back();
      if (stc % 16 == 15) sta = sta - (sta >> 6) + lvl[15:0];
      stc++;
    end
  end
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hE188));
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    spi_master_model_i.xfer(32'h2000_0000, 32, rsp);
    `CHK("first", rate_spi_pkg::FIRST_RESPONSE, rsp)
    $display("test first done");
    for (int k = 0; k < 2; k++) begin
      lvl = $signed(16'($urandom));
      repeat (1200) @(posedge i_sys_clk);
      for (int w = 0; w < 8 && tick != 5; w++) @(posedge i_sys_clk);
      `CHK("rate", 16'(s2 >>> 12), filt)
      `CHK("stf", 16'(sta >> 6), stf)
      cmd = $urandom;
      cmd[29] = k == 0;
      repeat (2) spi_master_model_i.xfer(cmd, 32, rsp);
      `CHK("word", cmd, word)
      `CHK("st", rate_spi_pkg::RESP_STATUS_RATE << k, rsp & 32'h0C00_0000)
      $display("test %0d done", k);
    end
    for (int n = 31; n < 34; n += 2) begin
      spi_master_model_i.xfer(32'h2000_0000, n, rsp);
      `CHK("ferr", 1'b1, ferr)
      spi_master_model_i.xfer(32'h2000_0000, 32, rsp);
      `CHK("errw", rate_spi_pkg::ERROR_RESPONSE, rsp)
      `CHK("fok", 1'b0, ferr)
    end
    $display("test err done");
    `CHK("valid", 7, nv)
    tally_and_finish();
  end
endmodule // testbench
